// ---- src/dfs_fault_status.sv ----
// fault detection, operable logic and operator controls of a disk storage unit
// assumes panel switches and the controller enable line are asynchronous, controller requests and Wishbone on CLOCK
//
// Operation
// - operable needs heads, no fault, speed, plug, online
// - ready lamp follows operable
// - maintenance lamp: dc off or off line
// - write-inhibit button toggles inhibit state
// - multiple head selects set fault latch
// - read with write or erase faults
// - erase with no or both drivers faults
// - write driver without erase faults
// - select off cylinder or low voltage faults
// - fault clear resets latch, flags, registers
// - clearing sole blocker starts return-to-zero
// - plug drives one of nine address lines
// - off line refuses seek, read, write
// - source selector picks bus or status group
// - twelve-position select picks one of 28
// - maintenance fault lamp on any error bit
// - dc off drops spindle then power
// - first seek done at track zero
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status
  import dfs_pkg::*;
#(
  parameter int HEADS = DFS_HEADS,
  parameter int UNIT_LINES = DFS_UNIT_LINES
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // drive condition inputs
  input wire logic HEADS_LOADED,
  input wire logic [15:0] SPINDLE_RPM,
  input wire logic ON_CYLINDER,
  input wire logic AT_TRACK_ZERO,
  input wire logic LOW_VOLTAGE,
  input wire logic [HEADS-1:0] HEAD_SELECT,
  input wire logic READ_SELECT,
  input wire logic WRITE_SELECT,
  input wire logic ERASE_SELECT,
  input wire logic [1:0] WRITE_DRIVER,
  input wire logic [7:0] INBOUND_FILE_BUS,
  input wire logic [7:0] DRIVE_STATUS_IN,
  input wire logic DRIVE_STATUS_LOAD,
  input wire logic SEEK_FINISHED_SET,
  // controller side
  input wire logic CONTROLLER_ENABLE_LINE,
  input wire logic CTRL_SEEK_REQ,
  input wire logic CTRL_READ_REQ,
  input wire logic CTRL_WRITE_REQ,
  // panel switches
  input wire logic DC_SWITCH_ON,
  input wire logic ON_LINE_SWITCH,
  input wire logic WRITE_INHIBIT_BUTTON,
  input wire logic FAULT_BUTTON,
  input wire logic CLEAR_FAULT_BUTTON,
  input wire logic [UNIT_LINES-1:0] UNIT_PLUG,
  input wire logic SPARE_PLUG,
  input wire logic [1:0] STATUS_SOURCE,
  input wire logic [3:0] STATUS_SELECT,
  // outputs
  output logic OPERABLE,
  output logic READY_LAMP,
  output logic MAINTENANCE_LAMP,
  output logic WRITE_INHIBIT_LAMP,
  output logic FAULT_BUTTON_LAMP,
  output logic MAINT_FAULT_LAMP,
  output logic [UNIT_LINES-1:0] UNIT_ADDRESS,
  output logic UNIT_PLUG_LAMP,
  output logic STATUS_LAMP,
  output logic STATUS_TEST_N,
  output logic SEEK_GRANT,
  output logic READ_GRANT,
  output logic WRITE_GRANT,
  output logic RTZ_SEEK,
  output logic SPINDLE_DRIVE,
  output logic DC_POWER
);
  // ten single-bit inputs, select 4, source 2 and the spare plug beside the plug lines
  localparam int SW = 17 + UNIT_LINES;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  dfs_sync_if #(.WIDTH(SW)) sw_if ();
  assign sw_if.raw = {STATUS_SELECT, STATUS_SOURCE, SPARE_PLUG, UNIT_PLUG,
                      CLEAR_FAULT_BUTTON, FAULT_BUTTON, WRITE_INHIBIT_BUTTON,
                      ON_LINE_SWITCH, DC_SWITCH_ON, CONTROLLER_ENABLE_LINE,
                      HEADS_LOADED, LOW_VOLTAGE, ON_CYLINDER, AT_TRACK_ZERO};
  dfs_sync #(.WIDTH(SW)) u_sync (
    .clk(CLOCK),
    .rst(SYS_RST),
    .port(sw_if.sync_end)
  );

  logic [3:0] sel_s;
  logic [1:0] src_s;
  logic spare_s, clrb_s, fltb_s, winb_s, online_s, dcon_s, cen_s;
  logic loaded_s, lowv_s, oncyl_s, trk0_s;
  logic [UNIT_LINES-1:0] plug_s;
  assign {sel_s, src_s, spare_s, plug_s, clrb_s, fltb_s, winb_s, online_s, dcon_s,
          cen_s, loaded_s, lowv_s, oncyl_s, trk0_s} = sw_if.sync;

  ////////////////////////////////////////////////////////////////////////////
  // registered buttons and bus decode
  logic winb_q, fltb_q, clrb_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      winb_q <= 1'b0;
      fltb_q <= 1'b0;
      clrb_q <= 1'b0;
    end else begin
      winb_q <= winb_s;
      fltb_q <= fltb_s;
      clrb_q <= clrb_s;
    end
  end

  logic wb_req, wb_wr, wb_lane0;
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_req && WB_WE_I;
  assign wb_lane0 = WB_SEL_I[0];

  logic sw_clear;
  assign sw_clear = wb_wr && wb_lane0 && (WB_ADR_I == DFS_OFS_CTRL)
                    && WB_DAT_I[DFS_CTRL_FCLR_BIT];
  logic fault_clear;
  assign fault_clear = (fltb_s && !fltb_q) || (clrb_s && !clrb_q) || sw_clear;

  ////////////////////////////////////////////////////////////////////////////
  // fault detection, plain combinational conditions
  function automatic logic more_than_one(input logic [HEADS-1:0] v);
    return (v & (v - HEADS'(1))) != '0;
  endfunction

  logic any_sel;
  logic [7:0] cond;
  assign any_sel = READ_SELECT || WRITE_SELECT || ERASE_SELECT;
  always_comb begin
    cond = '0;
    cond[DFS_ERR_HEAD_BIT] = more_than_one(HEAD_SELECT);
    cond[DFS_ERR_RDWR_BIT] = READ_SELECT && WRITE_SELECT;
    cond[DFS_ERR_RDER_BIT] = READ_SELECT && ERASE_SELECT;
    cond[DFS_ERR_ERNODRV_BIT] = ERASE_SELECT && (WRITE_DRIVER == 2'b00);
    cond[DFS_ERR_ERBOTH_BIT] = ERASE_SELECT && (WRITE_DRIVER == 2'b11);
    cond[DFS_ERR_DRVNOER_BIT] = (WRITE_DRIVER != 2'b00) && !ERASE_SELECT;
    cond[DFS_ERR_NOCYL_BIT] = any_sel && !oncyl_s;
    cond[DFS_ERR_LOWV_BIT] = lowv_s;
  end

  // sticky error bits, set wins over clear
  logic [7:0] error_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      error_q <= DFS_ERR_RESET;
    end else if (fault_clear) begin
      error_q <= cond;
    end else begin
      error_q <= error_q | cond;
    end
  end

  logic fault_latch_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      fault_latch_q <= 1'b0;
    end else begin
      fault_latch_q <= (fault_clear ? 1'b0 : fault_latch_q) | (|cond);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive status registers and seek finished
  // a single clear may race a pending load; the operator presses again
  logic [7:0] drive_status_one_q, drive_status_two_q;
  logic seek_fin_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      drive_status_one_q <= DFS_DSB_RESET;
      drive_status_two_q <= DFS_DSB_RESET;
    end else if (DRIVE_STATUS_LOAD) begin
      drive_status_one_q <= DRIVE_STATUS_IN;
      drive_status_two_q <= drive_status_one_q;
    end else if (fault_clear) begin
      drive_status_one_q <= DFS_DSB_RESET;
      drive_status_two_q <= DFS_DSB_RESET;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      seek_fin_q <= 1'b0;
    end else if (SEEK_FINISHED_SET) begin
      seek_fin_q <= 1'b1;
    end else if (fault_clear) begin
      seek_fin_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write inhibit toggle
  logic winh_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      winh_q <= 1'b0;
    end else if (winb_s && !winb_q) begin
      winh_q <= !winh_q;
    end else if (wb_wr && wb_lane0 && (WB_ADR_I == DFS_OFS_CTRL)) begin
      winh_q <= WB_DAT_I[DFS_CTRL_WINH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power sequencing and plug
  logic spin_ok, spin_pwr_ok, plug_ok;
  assign spin_ok = SPINDLE_RPM > DFS_RPM_READY;
  assign spin_pwr_ok = SPINDLE_RPM >= DFS_RPM_POWER;
  // one-hot plug only, spare plug withholds the unit
  assign plug_ok = $onehot(plug_s) && !spare_s;

  logic dc_pwr_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      dc_pwr_q <= 1'b0;
    end else if (dcon_s) begin
      dc_pwr_q <= 1'b1;
    end else if (!spin_pwr_ok) begin
      dc_pwr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operable, return-to-zero and first seek
  logic others_ok, oper_d;
  logic seek_done_q, rtz_q, loaded_q;
  assign others_ok = loaded_s && spin_ok && plug_ok && online_s && cen_s;
  assign oper_d = others_ok && !fault_latch_q && seek_done_q;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= loaded_s;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rtz_q <= 1'b0;
    end else if (rtz_q && trk0_s) begin
      rtz_q <= 1'b0;
    end else if (fault_clear && fault_latch_q && others_ok) begin
      rtz_q <= 1'b1;
    end else if ((loaded_s && !loaded_q) || (wb_wr && wb_lane0 && (WB_ADR_I == DFS_OFS_CTRL)
                 && WB_DAT_I[DFS_CTRL_RTZ_BIT])) begin
      rtz_q <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      seek_done_q <= 1'b0;
    end else if (!loaded_s || rtz_q && !trk0_s) begin
      seek_done_q <= 1'b0;
    end else if (trk0_s) begin
      seek_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status sampling multiplexer
  logic [7:0] src_bits;
  logic picked;
  always_comb begin
    case (dfs_src_type'(src_s))
      DFS_SRC_FILE_BUS: src_bits = INBOUND_FILE_BUS;
      DFS_SRC_DRIVE_STATUS_ONE: src_bits = drive_status_one_q;
      DFS_SRC_DRIVE_STATUS_TWO: src_bits = drive_status_two_q;
      default: src_bits = '0;
    endcase
    // positions 0-7 per group, 8-11 fixed signals
    case (sel_s)
      4'h8: picked = fault_latch_q;
      4'h9: picked = seek_fin_q;
      4'hA: picked = winh_q;
      4'hB: picked = oper_d;
      default: picked = (sel_s < 4'h8) ? src_bits[sel_s[2:0]] : 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      OPERABLE <= 1'b0;
      READY_LAMP <= 1'b0;
      MAINTENANCE_LAMP <= 1'b1;
      WRITE_INHIBIT_LAMP <= 1'b0;
      FAULT_BUTTON_LAMP <= 1'b0;
      MAINT_FAULT_LAMP <= 1'b0;
      UNIT_ADDRESS <= '0;
      UNIT_PLUG_LAMP <= 1'b0;
      STATUS_LAMP <= 1'b0;
      STATUS_TEST_N <= 1'b1;
      SEEK_GRANT <= 1'b0;
      READ_GRANT <= 1'b0;
      WRITE_GRANT <= 1'b0;
      RTZ_SEEK <= 1'b0;
      SPINDLE_DRIVE <= 1'b0;
      DC_POWER <= 1'b0;
    end else begin
      OPERABLE <= oper_d;
      READY_LAMP <= oper_d;
      MAINTENANCE_LAMP <= !dcon_s || !online_s;
      WRITE_INHIBIT_LAMP <= winh_q;
      FAULT_BUTTON_LAMP <= fault_latch_q;
      MAINT_FAULT_LAMP <= |error_q;
      UNIT_ADDRESS <= plug_ok ? plug_s : '0;
      UNIT_PLUG_LAMP <= |plug_s;
      STATUS_LAMP <= picked;
      STATUS_TEST_N <= !picked;
      SEEK_GRANT <= CTRL_SEEK_REQ && oper_d;
      READ_GRANT <= CTRL_READ_REQ && oper_d;
      WRITE_GRANT <= CTRL_WRITE_REQ && oper_d && !winh_q;
      RTZ_SEEK <= rtz_q;
      SPINDLE_DRIVE <= dcon_s;
      DC_POWER <= dc_pwr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone read and ack
  logic [31:0] rd_d;
  always_comb begin
    case (WB_ADR_I)
      DFS_OFS_CTRL: rd_d = {29'h0, rtz_q, winh_q, 1'b0};
      DFS_OFS_STATUS: rd_d = {24'h0, spin_ok, dc_pwr_q, rtz_q, seek_fin_q, online_s,
                              winh_q, fault_latch_q, oper_d};
      DFS_OFS_ERROR: rd_d = {24'h0, error_q};
      DFS_OFS_DRIVE_STATUS_ONE: rd_d = {24'h0, drive_status_one_q};
      DFS_OFS_DRIVE_STATUS_TWO: rd_d = {24'h0, drive_status_two_q};
      DFS_OFS_SPEED: rd_d = {16'h0, SPINDLE_RPM};
      default: rd_d = DFS_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= rd_d;
    end
  end
endmodule // dfs_fault_status
`default_nettype wire

// ---- src/dfs_pkg.sv ----
// package for the disk drive fault and status block
// assumes a single 25 MHz system clock and synchronous active-high reset
package dfs_pkg;
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] DFS_OFS_CTRL = 8'h00;
  localparam logic [7:0] DFS_OFS_STATUS = 8'h04;
  localparam logic [7:0] DFS_OFS_ERROR = 8'h08;
  localparam logic [7:0] DFS_OFS_DRIVE_STATUS_ONE = 8'h0C;
  localparam logic [7:0] DFS_OFS_DRIVE_STATUS_TWO = 8'h10;
  localparam logic [7:0] DFS_OFS_SPEED = 8'h14;
  // control register fields
  localparam int DFS_CTRL_FCLR_BIT = 0;
  localparam int DFS_CTRL_WINH_BIT = 1;
  localparam int DFS_CTRL_RTZ_BIT = 2;
  // status register fields
  localparam int DFS_ST_OPER_BIT = 0;
  localparam int DFS_ST_FAULT_BIT = 1;
  localparam int DFS_ST_WINH_BIT = 2;
  localparam int DFS_ST_ONLINE_BIT = 3;
  localparam int DFS_ST_SEEKFIN_BIT = 4;
  localparam int DFS_ST_RTZ_BIT = 5;
  localparam int DFS_ST_DCPWR_BIT = 6;
  localparam int DFS_ST_SPINDLE_BIT = 7;
  // error register fields
  localparam int DFS_ERR_HEAD_BIT = 0;
  localparam int DFS_ERR_RDWR_BIT = 1;
  localparam int DFS_ERR_RDER_BIT = 2;
  localparam int DFS_ERR_ERNODRV_BIT = 3;
  localparam int DFS_ERR_ERBOTH_BIT = 4;
  localparam int DFS_ERR_DRVNOER_BIT = 5;
  localparam int DFS_ERR_NOCYL_BIT = 6;
  localparam int DFS_ERR_LOWV_BIT = 7;
  // reset values
  localparam logic [7:0] DFS_ERR_RESET = 8'h00;
  localparam logic [7:0] DFS_DSB_RESET = 8'h00;
  localparam logic [31:0] DFS_UNMAPPED_READ = 32'h0000_0000;
  // spindle speed thresholds in rpm
  localparam logic [15:0] DFS_RPM_READY = 16'h0898;  // 2200
  localparam logic [15:0] DFS_RPM_POWER = 16'h07D0;  // 2000
  // geometry of the operator controls
  localparam int DFS_UNIT_LINES = 9;
  localparam int DFS_HEADS = 19;
  localparam int DFS_SEL_POS = 12;
  // status source selector
  typedef enum logic [1:0] {
    DFS_SRC_FILE_BUS,
    DFS_SRC_DRIVE_STATUS_ONE,
    DFS_SRC_DRIVE_STATUS_TWO,
    DFS_SRC_NONE
  } dfs_src_type;
endpackage

// ---- src/dfs_sync_if.sv ----
// interface carrying the synchronised panel and controller inputs
// assumes both ends share the CLOCK domain of the top module
`timescale 1ns/1ps
`default_nettype none
interface dfs_sync_if #(parameter int WIDTH = 64);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;
  modport sync_end (input raw, output sync);
  modport user_end (output raw, input sync);
endinterface // dfs_sync_if
`default_nettype wire

// ---- src/dfs_sync.sv ----
// two-stage synchroniser for a vector of asynchronous inputs
// assumes the receiving logic runs on the same clock
`timescale 1ns/1ps
`default_nettype none
module dfs_sync #(
  parameter int WIDTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  dfs_sync_if.sync_end port
);
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= port.raw;
      stage2_q <= stage1_q;
    end
  end

  assign port.sync = stage2_q;
endmodule // dfs_sync
`default_nettype wire

// ---- bench/dfs_fault_status_sva.sv ----
// concurrent checks on the top ports of the fault and status block
// assumes it is bound into dfs_fault_status and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status_sva
  import dfs_pkg::*;
#(
  parameter int HEADS = DFS_HEADS
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [HEADS-1:0] HEAD_SELECT,
  input wire logic READ_SELECT,
  input wire logic WRITE_SELECT,
  input wire logic ERASE_SELECT,
  input wire logic [1:0] WRITE_DRIVER,
  input wire logic [15:0] SPINDLE_RPM,
  input wire logic ON_LINE_SWITCH,
  input wire logic DC_SWITCH_ON,
  input wire logic OPERABLE,
  input wire logic READY_LAMP,
  input wire logic FAULT_BUTTON_LAMP,
  input wire logic MAINT_FAULT_LAMP,
  input wire logic MAINTENANCE_LAMP,
  input wire logic STATUS_LAMP,
  input wire logic STATUS_TEST_N
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  //////////////////////////////////////////////////////////////////////
  // lamp may trail operable by one register stage, never more
  ready_on_a: assert property (OPERABLE && $past(OPERABLE) |-> READY_LAMP)
    else $error("ready lamp dark while operable");
  ready_off_a: assert property (READY_LAMP |-> OPERABLE || $past(OPERABLE))
    else $error("ready lamp lit without operable");
  head_fault_a: assert property ($countones(HEAD_SELECT) > 1 |->
    ##[1:3] (FAULT_BUTTON_LAMP && MAINT_FAULT_LAMP))
    else $error("no fault after multiple head select");
  read_clash_a: assert property (READ_SELECT && (WRITE_SELECT || ERASE_SELECT) |->
    ##[1:3] FAULT_BUTTON_LAMP)
    else $error("no fault after read clash");
  erase_drv_a: assert property (ERASE_SELECT && WRITE_DRIVER inside {2'h0, 2'h3} |->
    ##[1:3] FAULT_BUTTON_LAMP)
    else $error("no fault after erase driver mismatch");
  drv_erase_a: assert property (!ERASE_SELECT && WRITE_DRIVER != 2'h0 |->
    ##[1:3] FAULT_BUTTON_LAMP)
    else $error("no fault after driver without erase");
  rpm_oper_a: assert property ((SPINDLE_RPM <= DFS_RPM_READY) [*3] |-> !OPERABLE)
    else $error("operable at low spindle speed");
  maint_lamp_a: assert property ((!DC_SWITCH_ON || !ON_LINE_SWITCH) [*4] |->
    MAINTENANCE_LAMP)
    else $error("maintenance lamp dark");
  offline_a: assert property ((!ON_LINE_SWITCH) [*5] |-> !OPERABLE && !READY_LAMP)
    else $error("operable while off line");
  test_jack_a: assert property (STATUS_TEST_N != STATUS_LAMP)
    else $error("status jack not inverse of lamp");
endmodule // dfs_fault_status_sva
bind dfs_fault_status dfs_fault_status_sva #(.HEADS(HEADS)) u_sva (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .HEAD_SELECT(HEAD_SELECT), .READ_SELECT(READ_SELECT),
  .WRITE_SELECT(WRITE_SELECT), .ERASE_SELECT(ERASE_SELECT), .WRITE_DRIVER(WRITE_DRIVER),
  .SPINDLE_RPM(SPINDLE_RPM), .ON_LINE_SWITCH(ON_LINE_SWITCH), .DC_SWITCH_ON(DC_SWITCH_ON),
  .OPERABLE(OPERABLE), .READY_LAMP(READY_LAMP), .FAULT_BUTTON_LAMP(FAULT_BUTTON_LAMP),
  .MAINT_FAULT_LAMP(MAINT_FAULT_LAMP), .MAINTENANCE_LAMP(MAINTENANCE_LAMP),
  .STATUS_LAMP(STATUS_LAMP), .STATUS_TEST_N(STATUS_TEST_N)
);
`default_nettype wire

// ---- bench/dfs_ctrl_model.sv ----
// controller-side model: enabling line and operation requests
// assumes bench commands arrive on clk; requests are levels
`timescale 1ns/1ps
`default_nettype none
module dfs_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic want_en,
  input wire logic [2:0] want,
  input wire logic [8:0] unit_addr,
  output logic en,
  output logic [2:0] req
);
  always_ff @(posedge clk) begin
    if (rst) begin
      en <= 1'h0;
      req <= 3'h0;
    end else begin
      en <= want_en;
      req <= want & {3{want_en && (unit_addr != 9'h000)}};
    end
  end
endmodule // dfs_ctrl_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the disk fault and status block
// assumes the controller model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dfs_pkg::*;
;
  logic clock, sys_rst, cyc, stb, we, ack, ds_load, sf_set, dc_on, online, spare, en;
  logic heads, on_cyl, at_tz, low_v, rd_sel, wr_sel, er_sel, want_en, plug_l, st_l, st_n;
  logic winh_btn, flt_btn, clr_btn, oper, ready, maint, winh_l, flt_l, mflt_l, rtz, spin, dcpwr;
  logic [7:0] adr, fbus, dsin;
  logic [3:0] sel, pos;
  logic [31:0] wdat, rdat, d;
  logic [15:0] rpm;
  logic [18:0] hsel;
  logic [1:0] drv, src;
  logic [8:0] plug, uaddr;
  logic [2:0] want, req, grant;
  int errors, n_tests, ticks;
  dfs_fault_status u_dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .HEADS_LOADED(heads), .SPINDLE_RPM(rpm), .ON_CYLINDER(on_cyl), .AT_TRACK_ZERO(at_tz),
    .LOW_VOLTAGE(low_v), .HEAD_SELECT(hsel), .READ_SELECT(rd_sel), .WRITE_SELECT(wr_sel),
    .ERASE_SELECT(er_sel), .WRITE_DRIVER(drv), .INBOUND_FILE_BUS(fbus),
    .DRIVE_STATUS_IN(dsin), .DRIVE_STATUS_LOAD(ds_load), .SEEK_FINISHED_SET(sf_set),
    .CONTROLLER_ENABLE_LINE(en), .CTRL_SEEK_REQ(req[0]), .CTRL_READ_REQ(req[1]),
    .CTRL_WRITE_REQ(req[2]), .DC_SWITCH_ON(dc_on), .ON_LINE_SWITCH(online),
    .WRITE_INHIBIT_BUTTON(winh_btn), .FAULT_BUTTON(flt_btn), .CLEAR_FAULT_BUTTON(clr_btn),
    .UNIT_PLUG(plug), .SPARE_PLUG(spare), .STATUS_SOURCE(src), .STATUS_SELECT(pos),
    .OPERABLE(oper), .READY_LAMP(ready), .MAINTENANCE_LAMP(maint),
    .WRITE_INHIBIT_LAMP(winh_l), .FAULT_BUTTON_LAMP(flt_l), .MAINT_FAULT_LAMP(mflt_l),
    .UNIT_ADDRESS(uaddr), .UNIT_PLUG_LAMP(plug_l), .STATUS_LAMP(st_l), .STATUS_TEST_N(st_n),
    .SEEK_GRANT(grant[0]), .READ_GRANT(grant[1]), .WRITE_GRANT(grant[2]), .RTZ_SEEK(rtz),
    .SPINDLE_DRIVE(spin), .DC_POWER(dcpwr)
  );
  dfs_ctrl_model u_ctl (.clk(clock), .rst(sys_rst), .want_en(want_en), .want(want),
    .unit_addr(uaddr), .en(en), .req(req));
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      errors++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_on(ref logic s);
    int k;
    k = 0;
    while (s !== 1'h1 && k < 500) begin
      @(posedge clock);
      k++;
    end
    check(s, 1'h1);
  endtask
  // one classic cycle; a read compares against v
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    {cyc, stb, we, sel} <= {2'h3, w, 4'hF};
    adr <= a;
    wdat <= w ? v : 32'h0000_0000;
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'h1 && k < 50);
    if (ack !== 1'h1)
      errors++;
    d = rdat;
    {cyc, stb, we} <= 3'h0;
    @(posedge clock);
    if (!w)
      check(d, v);
  endtask
  // buttons act on the rising edge, so hold long enough to pass the synchronisers
  task automatic press(input int b);
    {winh_btn, flt_btn, clr_btn} <= {b == 0, b == 1, b == 2};
    cyc_n(4);
    {winh_btn, flt_btn, clr_btn} <= 3'h0;
    cyc_n(4);
  endtask
  task automatic ask(input int k, input logic exp);
    want <= 3'h1 << k;
    cyc_n(4);
    check(grant[k], exp);
    want <= 3'h0;
    cyc_n(3);
  endtask
  task automatic pat(input int k);
    hsel <= (k == 0) ? 19'h0_0003 : 19'h0_0001;
    rd_sel <= k == 1 || k == 2;
    wr_sel <= k == 1 || k == 6;
    er_sel <= (k >= 2 && k <= 4) || k == 6;
    drv <= (k == 2 || k == 5 || k == 6) ? 2'h1 : (k == 4 ? 2'h3 : 2'h0);
    on_cyl <= k != 6;
    low_v <= k == 7;
  endtask
  task automatic blk(input int i, input logic b);
    rpm <= (b && i == 0) ? DFS_RPM_READY : DFS_RPM_READY + 16'h0001;
    plug <= (b && i == 1) ? 9'h000 : 9'h008;
    want_en <= !(b && i == 2);
    spare <= b && i == 3;
    online <= !(b && i == 4);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_start();
    heads <= 1'h1;
    wait_on(rtz);
    at_tz <= 1'h1;
    wait_on(oper);
    cyc_n(2);
    check({ready, maint, plug_l, uaddr}, {3'h5, 9'h008});
  endtask
  task automatic t_block();
    for (int i = 0; i < 5; i++) begin
      blk(i, 1'h1);
      cyc_n(6);
      check({oper, ready}, 2'h0);
      if (i == 4) begin
        check(maint, 1'h1);
        for (int k = 0; k < 3; k++)
          ask(k, 1'h0);
      end
      blk(i, 1'h0);
      wait_on(oper);
    end
    ask(0, 1'h1);
  endtask
  task automatic t_inhibit();
    press(0);
    check(winh_l, 1'h1);
    ask(2, 1'h0);
    ask(1, 1'h1);
    press(0);
    check(winh_l, 1'h0);
    ask(2, 1'h1);
    wb(1'h1, DFS_OFS_CTRL, 32'h0000_0002);
    cyc_n(2);
    check(winh_l, 1'h1);
    wb(1'h0, DFS_OFS_CTRL, 32'h0000_0002);
    wb(1'h1, DFS_OFS_CTRL, 32'h0000_0000);
    wb(1'h0, 8'h3C, 32'h0000_0000);
  endtask
  task automatic t_faults();
    for (int k = 0; k < 8; k++) begin
      pat(k);
      cyc_n(4);
      pat(8);
      at_tz <= 1'h0;
      cyc_n(5);
      check({flt_l, mflt_l, oper}, 3'h6);
      wb(1'h0, DFS_OFS_ERROR, 32'h0000_0001 << k);
      press((k % 2) + 1);
      check({flt_l, mflt_l}, 2'h0);
      wb(1'h0, DFS_OFS_ERROR, 32'h0000_0000);
      wait_on(rtz);
      at_tz <= 1'h1;
      wait_on(oper);
    end
  endtask
  task automatic t_status();
    logic [7:0] v [3];
    v = '{8'hA5, 8'h81, 8'h3C};
    fbus <= v[0];
    {ds_load, dsin} <= {1'h1, v[2]};
    @(posedge clock);
    dsin <= v[1];
    @(posedge clock);
    ds_load <= 1'h0;
    for (int s = 0; s < 3; s++) begin
      for (int b = 0; b < 8; b++) begin
        {src, pos} <= {s[1:0], b[3:0]};
        cyc_n(4);
        check({st_l, st_n}, {v[s][b], !v[s][b]});
      end
    end
    wb(1'h0, DFS_OFS_DRIVE_STATUS_ONE, {24'h00_0000, v[1]});
    wb(1'h0, DFS_OFS_DRIVE_STATUS_TWO, {24'h00_0000, v[2]});
    sf_set <= 1'h1;
    @(posedge clock);
    {sf_set, pos} <= {1'h0, 4'h9};
    cyc_n(4);
    check(st_l, 1'h1);
    {ds_load, dsin} <= {1'h1, 8'h55};
    press(2);
    ds_load <= 1'h0;
    check(st_l, 1'h0);
    wb(1'h0, DFS_OFS_DRIVE_STATUS_ONE, 32'h0000_0055);
    press(2);
    wb(1'h0, DFS_OFS_DRIVE_STATUS_ONE, 32'h0000_0000);
    wb(1'h0, DFS_OFS_DRIVE_STATUS_TWO, 32'h0000_0000);
  endtask
  task automatic t_power();
    dc_on <= 1'h0;
    cyc_n(5);
    check({spin, maint, dcpwr}, 3'h3);
    rpm <= DFS_RPM_POWER;
    cyc_n(5);
    check(dcpwr, 1'h1);
    rpm <= DFS_RPM_POWER - 16'h0001;
    cyc_n(5);
    check({dcpwr, oper}, 2'h0);
  endtask
  initial begin
    sys_rst = 1'h1;
    errors = 0;
    n_tests = 0;
    ticks = 0;
    {cyc, stb, we, heads, at_tz, low_v, rd_sel, wr_sel, er_sel, ds_load, sf_set} = '0;
    {winh_btn, flt_btn, clr_btn, spare, sel, adr, wdat, fbus, dsin, src, pos, drv, want} = '0;
    {dc_on, online, on_cyl, want_en} = 4'hF;
    hsel = 19'h0_0001;
    plug = 9'h008;
    rpm = DFS_RPM_READY + 16'h0001;
    repeat (20) @(posedge clock);
    sys_rst <= 1'h0;
    t_start();
    t_block();
    t_inhibit();
    t_faults();
    t_status();
    t_power();
    results();
  end
endmodule // testbench
`default_nettype wire
